/* include/fault_action_pkg.sv */
// Package with command codes, field layout, reset values and timing for current fault handling
package fault_action_pkg;
    localparam int CHANNELS = 2;
    localparam logic [7:0] CMD_OC_ACTION = 8'hE5;
    localparam logic [7:0] CMD_UC_ACTION = 8'hE6;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] ACTION_RESET = 8'h80;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [1:0] MODE_LATCH = 2'h2;
    localparam logic [1:0] MODE_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam int CLK_HZ = 100000000;
    localparam int RETRY_UNIT_MS = 35;
    localparam int UNIT_CYCLES = CLK_HZ / 1000 * RETRY_UNIT_MS;
    localparam int UNIT_CNT_W = 22;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] retry;
        logic [2:0] delay;
    } action_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [7:0] data;
        logic page;
    } cmd_t;

    typedef enum logic [1:0] {
        RUNNING,
        LATCHED_OFF,
        HOLD_OFF,
        RETRY_WAIT
    } chan_state_t;
endpackage

/* rtl/retry_tick_gen.sv */
// Prescaler producing one-cycle pulses every retry time unit
`timescale 1ns/1ps
module retry_tick_gen #(
    parameter int UNIT_CYCLES = fault_action_pkg::UNIT_CYCLES
) (
    input wire logic i_ref_clk, // System clock
    input wire logic i_rst,     // Synchronous reset
    output logic o_tick         // One pulse per retry unit
);
    logic [fault_action_pkg::UNIT_CNT_W-1:0] count;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (count == fault_action_pkg::UNIT_CNT_W'(UNIT_CYCLES - 1)) begin
            count <= '0;
            o_tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule

/* rtl/current_fault_response.sv */
// Per-channel overcurrent and undercurrent fault response logic
`timescale 1ns/1ps
module current_fault_response #(
    parameter int UNIT_CYCLES = fault_action_pkg::UNIT_CYCLES
) (
    input wire logic i_ref_clk,                   // 100 MHz clock
    input wire logic i_rst,                       // Synchronous reset, high
    input wire fault_action_pkg::cmd_t i_cmd,     // Decoded host command
    input wire logic [1:0] i_rd_page,             // Page for readback
    input wire logic [1:0] i_oc_fault,            // Overcurrent detect per channel
    input wire logic [1:0] i_uc_fault,            // Undercurrent detect per channel
    input wire logic [1:0] i_on_request,          // Channel commanded on
    input wire logic i_bias_ok,                   // Bias power good
    input wire logic [1:0] i_other_shutdown,      // Other shutdown fault per channel
    output logic [1:0] o_output_enable,           // Output enable per channel
    output logic [1:0] o_status_oc,               // Sticky overcurrent status
    output logic [1:0] o_status_uc,               // Sticky undercurrent status
    output logic o_host_alert_line_n,             // Alert, low active
    output logic [7:0] o_oc_action_rd,            // Overcurrent action of read page
    output logic [7:0] o_uc_action_rd             // Undercurrent action of read page
);
    localparam int N = fault_action_pkg::CHANNELS;

    fault_action_pkg::action_t overcurrent_fault_action [N];
    fault_action_pkg::action_t undercurrent_fault_action [N];
    fault_action_pkg::chan_state_t state [N];
    logic [2:0] wait_units [N];
    logic [2:0] wait_limit [N];
    fault_action_pkg::action_t act_sel [N];
    logic [N-1:0] fault_now;
    logic [N-1:0] stop_now;
    logic [N-1:0] trip;
    logic [N-1:0] restart_due;
    logic [N-1:0] restart_now;
    logic tick;
    logic clear_faults;

    // Effective action for a channel: overcurrent takes precedence
    function automatic fault_action_pkg::action_t pick_action(
        input logic oc,
        input fault_action_pkg::action_t oc_act,
        input fault_action_pkg::action_t uc_act
    );
        return oc ? oc_act : uc_act;
    endfunction

    // Mode and retry field decoding
    function automatic logic holds_while_faulted(input fault_action_pkg::action_t a);
        return a.mode == fault_action_pkg::MODE_HOLD;
    endfunction

    function automatic logic retries_forever(input fault_action_pkg::action_t a);
        return a.retry == fault_action_pkg::RETRY_FOREVER;
    endfunction

    retry_tick_gen #(.UNIT_CYCLES(UNIT_CYCLES)) u_tick (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    assign clear_faults = i_cmd.valid && i_cmd.code == fault_action_pkg::CMD_CLEAR_FAULTS;

    // Configuration registers per page
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int c = 0; c < N; c++) begin
                overcurrent_fault_action[c] <= fault_action_pkg::ACTION_RESET;
                undercurrent_fault_action[c] <= fault_action_pkg::ACTION_RESET;
            end
        end else if (i_cmd.valid) begin
            if (i_cmd.code == fault_action_pkg::CMD_OC_ACTION) begin
                overcurrent_fault_action[i_cmd.page] <= i_cmd.data;
            end
            if (i_cmd.code == fault_action_pkg::CMD_UC_ACTION) begin
                undercurrent_fault_action[i_cmd.page] <= i_cmd.data;
            end
        end
    end

    // Readback of the selected page
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_oc_action_rd <= fault_action_pkg::ACTION_RESET;
            o_uc_action_rd <= fault_action_pkg::ACTION_RESET;
        end else begin
            o_oc_action_rd <= overcurrent_fault_action[i_rd_page[0]];
            o_uc_action_rd <= undercurrent_fault_action[i_rd_page[0]];
        end
    end

    // Sticky status; a new fault wins over a simultaneous clear
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_status_oc <= '0;
            o_status_uc <= '0;
        end else begin
            o_status_oc <= (clear_faults ? '0 : o_status_oc) | i_oc_fault;
            o_status_uc <= (clear_faults ? '0 : o_status_uc) | i_uc_fault;
        end
    end

    // Alert stays low while any status bit is held or a fault is present
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_host_alert_line_n <= 1'b1;
        end else begin
            o_host_alert_line_n <= ~(|((clear_faults ? '0 : (o_status_oc | o_status_uc))
                                       | i_oc_fault | i_uc_fault));
        end
    end

    // Per-channel decode shared by the state, delay and enable logic
    always_comb begin
        for (int c = 0; c < N; c++) begin
            act_sel[c] = pick_action(i_oc_fault[c], overcurrent_fault_action[c],
                                     undercurrent_fault_action[c]);
            fault_now[c] = i_oc_fault[c] | i_uc_fault[c];
            stop_now[c] = !i_on_request[c] || !i_bias_ok || i_other_shutdown[c];
            trip[c] = fault_now[c] && i_on_request[c]
                && state[c] == fault_action_pkg::RUNNING;
            restart_due[c] = state[c] == fault_action_pkg::RETRY_WAIT && !stop_now[c]
                && tick && wait_units[c] == wait_limit[c];
        end
    end

    // Response state per channel
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int c = 0; c < N; c++) begin
                state[c] <= fault_action_pkg::RUNNING;
            end
        end else begin
            for (int c = 0; c < N; c++) begin
                case (state[c])
                    fault_action_pkg::RUNNING: begin
                        if (trip[c]) begin
                            if (holds_while_faulted(act_sel[c])) begin
                                state[c] <= fault_action_pkg::HOLD_OFF;
                            end else if (retries_forever(act_sel[c])) begin
                                state[c] <= fault_action_pkg::RETRY_WAIT;
                            end else begin
                                state[c] <= fault_action_pkg::LATCHED_OFF;
                            end
                        end
                    end
                    fault_action_pkg::HOLD_OFF: begin
                        if (!fault_now[c]) begin
                            state[c] <= fault_action_pkg::RUNNING;
                        end
                    end
                    fault_action_pkg::LATCHED_OFF: begin
                        if (clear_faults || !i_on_request[c]) begin
                            state[c] <= fault_action_pkg::RUNNING;
                        end
                    end
                    fault_action_pkg::RETRY_WAIT: begin
                        if (stop_now[c]) begin
                            state[c] <= fault_action_pkg::LATCHED_OFF;
                        end else if (restart_due[c]) begin
                            // Restart without checking fault; a fault then re-enters
                            state[c] <= fault_action_pkg::RUNNING;
                        end
                    end
                    default: begin
                        state[c] <= fault_action_pkg::LATCHED_OFF;
                    end
                endcase
            end
        end
    end

    // Retry delay counter, restarted at every attempt
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int c = 0; c < N; c++) begin
                wait_units[c] <= '0;
                wait_limit[c] <= '0;
            end
        end else begin
            for (int c = 0; c < N; c++) begin
                if (trip[c]) begin
                    wait_units[c] <= '0;
                    wait_limit[c] <= act_sel[c].delay;
                end else if (state[c] == fault_action_pkg::RETRY_WAIT && tick
                             && wait_units[c] != wait_limit[c]) begin
                    wait_units[c] <= wait_units[c] + 3'h1;
                end
            end
        end
    end

    // A restart attempt drives the output once even while the fault stays
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            restart_now <= '0;
        end else begin
            for (int c = 0; c < N; c++) begin
                restart_now[c] <= restart_due[c] && fault_now[c];
            end
        end
    end

    // Output enables follow the sequencer; a fresh fault cuts them at once
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_output_enable <= '0;
        end else begin
            for (int c = 0; c < N; c++) begin
                o_output_enable[c] <= !stop_now[c] && state[c] == fault_action_pkg::RUNNING
                    && (restart_now[c] || !fault_now[c]);
            end
        end
    end
endmodule

/* tb/pmbus_host_model.sv */
// Host model issuing decoded configuration commands
`timescale 1ns/1ps
module pmbus_host_model (
    input wire logic i_ref_clk, // Clock
    output fault_action_pkg::cmd_t o_cmd // Command
);
    initial o_cmd = '0;
    task automatic send(input logic [7:0] code, input logic [7:0] data, input logic page);
        @(negedge i_ref_clk);
        o_cmd = {1'h1, code, data, page};
        @(negedge i_ref_clk);
        // Released fields show inverted junk
        o_cmd = {1'h0, ~code, ~data, ~page};
    endtask
endmodule

/* tb/current_fault_response_sva.sv */
// Port checker for current fault response
`timescale 1ns/1ps
module current_fault_response_sva (
    input wire logic i_ref_clk, // Clock
    input wire logic i_rst, // Reset
    input wire fault_action_pkg::cmd_t i_cmd, // Command
    input wire logic [1:0] i_rd_page, // Read page
    input wire logic [1:0] i_oc_fault, // OC detect
    input wire logic [1:0] i_uc_fault, // UC detect
    input wire logic [1:0] i_on_request, // On request
    input wire logic [1:0] o_output_enable, // Enable
    input wire logic [1:0] o_status_oc, // OC status
    input wire logic [1:0] o_status_uc, // UC status
    input wire logic o_host_alert_line_n, // Alert
    input wire logic [7:0] o_oc_action_rd // OC readback
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire logic clr = i_cmd.valid && i_cmd.code == fault_action_pkg::CMD_CLEAR_FAULTS;
    wire logic [3:0] st = {o_status_oc, o_status_uc};
    sequence oc_wr0;
        i_cmd.valid && i_cmd.code == fault_action_pkg::CMD_OC_ACTION && !i_cmd.page;
    endsequence
    sequence quiet2;
        (!i_cmd.valid && !i_rd_page[0])[*2];
    endsequence
    a_oc_status_set: assert property (i_oc_fault[0] |=> o_status_oc[0])
        else $error("overcurrent status not set");
    a_uc_status_set: assert property (i_uc_fault[0] |=> o_status_uc[0])
        else $error("undercurrent status not set");
    a_alert_follows: assert property (st != 4'h0 |-> !o_host_alert_line_n)
        else $error("alert high with status set");
    a_fault_disables: assert property ($rose(i_oc_fault[0]) |=> !o_output_enable[0])
        else $error("output not disabled on fault");
    a_off_disables: assert property (!i_on_request[0] |=> !o_output_enable[0])
        else $error("output enabled while off");
    a_status_sticky: assert property (!clr |=> (st & $past(st)) == $past(st))
        else $error("status dropped without clear");
    a_clear_works: assert property (clr && !i_oc_fault && !i_uc_fault |=> st == 4'h0)
        else $error("status kept after clear");
    a_readback_oc: assert property (oc_wr0 ##1 quiet2 |=> o_oc_action_rd == $past(i_cmd.data, 3))
        else $error("readback differs from write");
endmodule
bind current_fault_response current_fault_response_sva u_sva (.i_ref_clk, .i_rst, .i_cmd,
    .i_rd_page, .i_oc_fault, .i_uc_fault, .i_on_request, .o_output_enable, .o_status_oc,
    .o_status_uc, .o_host_alert_line_n, .o_oc_action_rd);

/* tb/current_fault_response_tb.sv */
// Self-checking bench for current fault response
`timescale 1ns/1ps
module current_fault_response_tb;
    localparam int UNIT = 20;
    logic i_ref_clk = 1'h0, i_rst = 1'h1;
    logic [1:0] i_rd_page = 2'h0, oc = 2'h0, uc = 2'h0, on = 2'h0, en, s_oc, s_uc, look = 2'h0;
    logic alert_n, bias = 1'h1;
    logic [1:0] other = 2'h0;
    logic [7:0] rd_oc, rd_uc, wa, wb, rnd = 8'h08;
    logic [15:0] obs, ivl, exp_q[$];
    fault_action_pkg::cmd_t cmd;
    int num_errors = 0, tests_run = 0, a, b;
    always #5 i_ref_clk = ~i_ref_clk;
    pmbus_host_model u_pmbus_host_model (.i_ref_clk, .o_cmd(cmd));
    current_fault_response #(.UNIT_CYCLES(UNIT)) u_current_fault_response (.i_ref_clk, .i_rst,
        .i_cmd(cmd), .i_rd_page, .i_oc_fault(oc), .i_uc_fault(uc), .i_on_request(on),
        .i_bias_ok(bias), .i_other_shutdown(other), .o_output_enable(en), .o_status_oc(s_oc),
        .o_status_uc(s_uc), .o_host_alert_line_n(alert_n), .o_oc_action_rd(rd_oc),
        .o_uc_action_rd(rd_uc));
    assign obs = look == 2'h1 ? {rd_oc, rd_uc} :
        look == 2'h2 ? {9'h000, s_oc, s_uc, alert_n, en} : ivl;
    always @(posedge i_ref_clk) begin
        if (look != 2'h0) begin
            tests_run++;
            if (exp_q.size() == 0 || obs !== exp_q[0]) begin
                num_errors++;
                $display("unexpected at %0t: got %h expected %h", $time, obs, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [1:0] sel, input logic [15:0] e);
        @(negedge i_ref_clk);
        exp_q.push_back(e);
        look = sel;
        @(negedge i_ref_clk);
        look = 2'h0;
    endtask
    task automatic wait_en(input logic v, output int n);
        n = 0;
        while (en[0] !== v) begin
            @(negedge i_ref_clk);
            n++;
            if (n > 400) begin
                num_errors++;
                end_of_test();
            end
        end
    endtask
    task automatic count_on(input int n);
        ivl = 16'h0000;
        repeat (n) begin
            @(negedge i_ref_clk);
            ivl = ivl + 16'(en[0]);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_ref_clk);
        @(negedge i_ref_clk) i_rst = 1'h0;
        on = 2'h3;
        chk(2'h1, 16'h8080);
        rnd = lfsr(rnd);
        wa = {2'h3, 3'h0, rnd[2:0]};
        wb = {2'h2, 3'h7, rnd[5:3]};
        i_rd_page = 2'h1;
        u_pmbus_host_model.send(fault_action_pkg::CMD_OC_ACTION, wa, 1'h1);
        u_pmbus_host_model.send(fault_action_pkg::CMD_UC_ACTION, wb, 1'h1);
        repeat (2) @(negedge i_ref_clk);
        chk(2'h1, {wa, wb});
        i_rd_page = 2'h0;
        chk(2'h1, 16'h8080);
        @(negedge i_ref_clk) oc = 2'h1;
        @(negedge i_ref_clk) oc = 2'h0;
        repeat (30) @(negedge i_ref_clk);
        chk(2'h2, 16'h0022);
        u_pmbus_host_model.send(fault_action_pkg::CMD_CLEAR_FAULTS, 8'h00, 1'h0);
        repeat (3) @(negedge i_ref_clk);
        chk(2'h2, 16'h0007);
        u_pmbus_host_model.send(fault_action_pkg::CMD_UC_ACTION, 8'hC0, 1'h0);
        @(negedge i_ref_clk) uc = 2'h1;
        repeat (10) @(negedge i_ref_clk);
        chk(2'h2, 16'h000A);
        uc = 2'h0;
        repeat (3) @(negedge i_ref_clk);
        chk(2'h2, 16'h000B);
        u_pmbus_host_model.send(fault_action_pkg::CMD_CLEAR_FAULTS, 8'h00, 1'h0);
        rnd = lfsr(rnd);
        u_pmbus_host_model.send(fault_action_pkg::CMD_OC_ACTION, {5'h17, rnd[2:0]}, 1'h0);
        oc = 2'h1;
        wait_en(1'h0, a);
        wait_en(1'h1, a);
        wait_en(1'h0, a);
        wait_en(1'h1, b);
        ivl = 16'(a + b);
        chk(2'h3, 16'((rnd[2:0] + 1) * UNIT));
        bias = 1'h0;
        repeat (3) @(negedge i_ref_clk);
        chk(2'h2, 16'h0020);
        bias = 1'h1;
        count_on(200);
        chk(2'h3, 16'h0000);
        on = 2'h2;
        repeat (5) @(negedge i_ref_clk);
        chk(2'h2, 16'h0022);
        other = 2'h1;
        on = 2'h3;
        repeat (5) @(negedge i_ref_clk);
        other = 2'h0;
        count_on(200);
        chk(2'h3, 16'h0000);
        end_of_test();
    end
endmodule
